//--- hw/qlid_fifo.sv
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module qlid_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 4
) (
  // clock and reset
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  // fill side
  input  wire logic             wr_valid_in,
  output logic                  wr_ready_out,
  input  wire logic [WIDTH-1:0] wr_data_in,
  // drain side
  output logic                  rd_valid_out,
  input  wire logic             rd_ready_in,
  output logic      [WIDTH-1:0] rd_data_out
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] FULL_COUNT = (AW+1)'(DEPTH);
  localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  wire              push = wr_valid_in && wr_ready_out;
  wire              pop  = rd_valid_out && rd_ready_in;

  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    return (p == LAST_PTR) ? '0 : p + AW'(1);
  endfunction

  // full and empty come from the true occupancy count
  assign wr_ready_out = (count != FULL_COUNT);
  assign rd_valid_out = (count != '0);
  assign rd_data_out  = mem[rd_ptr];

  always_ff @(posedge clk_in) begin
    if (push) begin
      mem[wr_ptr] <= wr_data_in;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) wr_ptr <= bump(wr_ptr);
      if (pop) rd_ptr <= bump(rd_ptr);
      if (push && !pop) count <= count + (AW+1)'(1);
      else if (pop && !push) count <= count - (AW+1)'(1);
    end
  end
endmodule
`default_nettype wire

//--- hw/qlid_top.sv
// quad-port indicator driver: open-drain indicators and serial indicator link
`timescale 1ns/1ps
`default_nettype none
module qlid_top (
  // clocks and reset
  input  wire logic                                             ref_clk_in,
  input  wire logic                                             link_clk_in,
  input  wire logic                                             rstn_in,
  // per-port status from the transceiver core, ref_clk domain
  input  wire logic [qlid_pkg::NUM_PORTS-1:0]                   tx_active_in,
  input  wire logic [qlid_pkg::NUM_PORTS-1:0]                   rx_active_in,
  input  wire logic [qlid_pkg::NUM_PORTS-1:0]                   link_up_in,
  input  wire logic [qlid_pkg::NUM_PORTS-1:0]                   full_duplex_in,
  input  wire logic [qlid_pkg::NUM_PORTS-1:0]                   speed_100_in,
  input  wire logic [qlid_pkg::NUM_PORTS-1:0]                   collision_in,
  // indicator meaning selects, two bits per port, port 0 lowest
  input  wire logic [qlid_pkg::NUM_PORTS*qlid_pkg::MODE_W-1:0]  first_mode_in,
  input  wire logic [qlid_pkg::NUM_PORTS*qlid_pkg::MODE_W-1:0]  second_mode_in,
  input  wire logic [qlid_pkg::NUM_PORTS*qlid_pkg::MODE_W-1:0]  third_mode_in,
  // open-drain indicator pins, enable low while pulling the pin low
  input  wire logic [qlid_pkg::NUM_PORTS-1:0]                   port_indicator_first_in,
  output logic      [qlid_pkg::NUM_PORTS-1:0]                   port_indicator_first_out,
  output logic      [qlid_pkg::NUM_PORTS-1:0]                   port_indicator_first_oe_n_out,
  input  wire logic [qlid_pkg::NUM_PORTS-1:0]                   port_indicator_second_in,
  output logic      [qlid_pkg::NUM_PORTS-1:0]                   port_indicator_second_out,
  output logic      [qlid_pkg::NUM_PORTS-1:0]                   port_indicator_second_oe_n_out,
  input  wire logic [qlid_pkg::NUM_PORTS-1:0]                   port_indicator_third_in,
  output logic      [qlid_pkg::NUM_PORTS-1:0]                   port_indicator_third_out,
  output logic      [qlid_pkg::NUM_PORTS-1:0]                   port_indicator_third_oe_n_out,
  // serial indicator link, link_clk domain
  output logic                                                  serial_indicator_enable_out,
  output logic                                                  serial_indicator_shift_clock_out,
  output logic                                                  serial_indicator_bitstream_out
);
  import qlid_pkg::*;

  // ============================================================
  // reset release, one synchroniser per domain
  logic rst_meta;
  logic rst_n;
  logic lrst_meta;
  logic lrst_n;

  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  always_ff @(posedge link_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      lrst_meta <= 1'b0;
      lrst_n    <= 1'b0;
    end else begin
      lrst_meta <= 1'b1;
      lrst_n    <= lrst_meta;
    end
  end

  // ============================================================
  // status gathering and indicator selection
  function automatic logic [BITS_PER_PORT-1:0] port_status(input int p);
    logic [BITS_PER_PORT-1:0] s;
    s         = '0;
    s[ST_TX]   = tx_active_in[p];
    s[ST_RX]   = rx_active_in[p];
    s[ST_LINK] = link_up_in[p];
    s[ST_DUP]  = full_duplex_in[p];
    s[ST_SPD]  = speed_100_in[p];
    s[ST_COL]  = collision_in[p];
    return s;
  endfunction

  // one picker serves all three indicators: status bit base + mode
  function automatic logic pick(input logic [BITS_PER_PORT-1:0] s, input int base,
                                input logic [MODE_W-1:0] mode);
    return s[base + int'(mode)];
  endfunction

  logic [FRAME_BITS-1:0]  snap;
  logic [NUM_PORTS-1:0]   next_first_lit;
  logic [NUM_PORTS-1:0]   next_second_lit;
  logic [NUM_PORTS-1:0]   next_third_lit;

  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
    wire [BITS_PER_PORT-1:0] st = port_status(p);
    assign snap[p*BITS_PER_PORT +: BITS_PER_PORT] = st;
    assign next_first_lit[p]  = pick(st, FIRST_BASE,
                                     first_mode_in[p*MODE_W +: MODE_W]);
    assign next_second_lit[p] = pick(st, SECOND_BASE,
                                     second_mode_in[p*MODE_W +: MODE_W]);
    assign next_third_lit[p]  = pick(st, THIRD_BASE,
                                     third_mode_in[p*MODE_W +: MODE_W]);
  end

  // ============================================================
  // open-drain pins: level is always low, the enable does the work
  logic drive_level;

  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      drive_level                    <= 1'b0;
      port_indicator_first_oe_n_out  <= {NUM_PORTS{OE_N_RESET}};
      port_indicator_second_oe_n_out <= {NUM_PORTS{OE_N_RESET}};
      port_indicator_third_oe_n_out  <= {NUM_PORTS{OE_N_RESET}};
    end else begin
      drive_level                    <= 1'b0;
      port_indicator_first_oe_n_out  <= ~next_first_lit;
      port_indicator_second_oe_n_out <= ~next_second_lit;
      port_indicator_third_oe_n_out  <= ~next_third_lit;
    end
  end

  assign port_indicator_first_out  = {NUM_PORTS{drive_level}};
  assign port_indicator_second_out = {NUM_PORTS{drive_level}};
  assign port_indicator_third_out  = {NUM_PORTS{drive_level}};

  // ============================================================
  // snapshot queue: the first snapshot after reset, then only changed snapshots, are queued
  // a burst of changes can queue up to four frames of lag; a stalled
  // writer keeps comparing against the live status, so nothing stale piles up
  logic                  primed;
  logic [FRAME_BITS-1:0] last_pushed;
  logic                  fifo_wr_ready;
  logic                  fifo_rd_valid;
  logic                  fifo_rd_ready;
  logic [FRAME_BITS-1:0] fifo_rd_data;
  wire                   fifo_wr_valid = !primed || (snap != last_pushed);

  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      primed      <= 1'b0;
      last_pushed <= FRAME_RESET;
    end else if (fifo_wr_valid && fifo_wr_ready) begin
      primed      <= 1'b1;
      last_pushed <= snap;
    end
  end

  qlid_fifo #(
    .WIDTH (FRAME_BITS),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_in       (ref_clk_in),
    .rst_n_in     (rst_n),
    .wr_valid_in  (fifo_wr_valid),
    .wr_ready_out (fifo_wr_ready),
    .wr_data_in   (snap),
    .rd_valid_out (fifo_rd_valid),
    .rd_ready_in  (fifo_rd_ready),
    .rd_data_out  (fifo_rd_data)
  );

  // ============================================================
  // word crossing: toggle request, toggle acknowledge
  // hold stays still until the link side has acknowledged it
  logic [FRAME_BITS-1:0] hold;
  logic                  req;
  logic                  ack_meta;
  logic                  ack_sync;
  logic                  ack;
  wire                   pending = (req != ack_sync);

  assign fifo_rd_ready = !pending;

  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      hold     <= FRAME_RESET;
      req      <= 1'b0;
      ack_meta <= 1'b0;
      ack_sync <= 1'b0;
    end else begin
      ack_meta <= ack;
      ack_sync <= ack_meta;
      if (fifo_rd_valid && !pending) begin
        hold <= fifo_rd_data;
        req  <= ~req;
      end
    end
  end

  // ============================================================
  // link side: shift clock, enable and serial bits
  qlid_link_state_t      state;
  logic                  req_meta;
  logic                  req_sync;
  logic                  have_frame;
  logic [FRAME_BITS-1:0] frame;
  logic [FRAME_BITS-1:0] shreg;
  logic [BIT_CNT_W-1:0]  bit_cnt;
  wire                   new_word   = (req_sync != ack);
  wire                   falling    = serial_indicator_shift_clock_out;
  wire [FRAME_BITS-1:0]  next_frame = new_word ? hold : frame;
  wire                   last_bit   = (bit_cnt == BIT_CNT_W'(FRAME_BITS - 1));

  always_ff @(posedge link_clk_in or negedge lrst_n) begin
    if (!lrst_n) begin
      req_meta <= 1'b0;
      req_sync <= 1'b0;
      serial_indicator_shift_clock_out <= 1'b0;
    end else begin
      req_meta <= req;
      req_sync <= req_meta;
      serial_indicator_shift_clock_out <= ~serial_indicator_shift_clock_out;
    end
  end

  // bits change as the shift clock falls, so the receiver samples on the rise
  always_ff @(posedge link_clk_in or negedge lrst_n) begin
    if (!lrst_n) begin
      state      <= QLID_GAP;
      ack        <= 1'b0;
      have_frame <= 1'b0;
      frame      <= FRAME_RESET;
      shreg      <= FRAME_RESET;
      bit_cnt    <= '0;
      serial_indicator_enable_out    <= ENA_RESET;
      serial_indicator_bitstream_out <= 1'b0;
    end else if (falling) begin
      case (state)
        QLID_GAP: begin
          if (new_word || have_frame) begin
            if (new_word) ack <= ~ack;
            have_frame <= 1'b1;
            frame      <= next_frame;
            shreg      <= next_frame >> 1;
            bit_cnt    <= '0;
            state      <= QLID_SHIFT;
            serial_indicator_enable_out    <= 1'b1;
            serial_indicator_bitstream_out <= next_frame[0];
          end
        end
        QLID_SHIFT: begin
          if (last_bit) begin
            state <= QLID_GAP;
            serial_indicator_enable_out    <= 1'b0;
            serial_indicator_bitstream_out <= 1'b0;
          end else begin
            shreg   <= shreg >> 1;
            bit_cnt <= bit_cnt + BIT_CNT_W'(1);
            serial_indicator_bitstream_out <= shreg[0];
          end
        end
        default: state <= QLID_GAP;
      endcase
    end
  end

  // ============================================================
  // checks
  localparam int ENA_CYCLES = FRAME_BITS * LINK_PER_BIT;
  logic [7:0] ena_run;
  logic [7:0] ena_len;

  always_ff @(posedge link_clk_in or negedge lrst_n) begin
    if (!lrst_n) begin
      ena_run <= '0;
      ena_len <= '0;
    end else if (serial_indicator_enable_out) begin
      ena_run <= ena_run + 8'h01;
    end else begin
      if (ena_run != '0) ena_len <= ena_run;
      ena_run <= '0;
    end
  end

  property p_first_default;
    @(posedge ref_clk_in) disable iff (!rst_n)
      (first_mode_in == '0) |=> (port_indicator_first_oe_n_out == ~$past(tx_active_in));
  endproperty
  a_first_default: assert property (p_first_default)
    else $error("first indicator does not follow transmit activity");

  property p_first_duplex;
    @(posedge ref_clk_in) disable iff (!rst_n)
      (first_mode_in[1:0] == 2'h3) |=>
        (port_indicator_first_oe_n_out[0] == !$past(full_duplex_in[0]));
  endproperty
  a_first_duplex: assert property (p_first_duplex)
    else $error("first indicator does not follow duplex");

  property p_second_default;
    @(posedge ref_clk_in) disable iff (!rst_n)
      (second_mode_in == '0) |=> (port_indicator_second_oe_n_out == ~$past(rx_active_in));
  endproperty
  a_second_default: assert property (p_second_default)
    else $error("second indicator does not follow receive activity");

  property p_second_speed;
    @(posedge ref_clk_in) disable iff (!rst_n)
      (second_mode_in[3:2] == 2'h3) |=>
        (port_indicator_second_oe_n_out[1] == !$past(speed_100_in[1]));
  endproperty
  a_second_speed: assert property (p_second_speed)
    else $error("second indicator does not follow speed");

  property p_third_default;
    @(posedge ref_clk_in) disable iff (!rst_n)
      (third_mode_in == '0) |=> (port_indicator_third_oe_n_out == ~$past(link_up_in));
  endproperty
  a_third_default: assert property (p_third_default)
    else $error("third indicator does not follow link");

  property p_third_collision;
    @(posedge ref_clk_in) disable iff (!rst_n)
      (third_mode_in[7:6] == 2'h3) |=>
        (port_indicator_third_oe_n_out[3] == !$past(collision_in[3]));
  endproperty
  a_third_collision: assert property (p_third_collision)
    else $error("third indicator does not follow collision");

  property p_enable_on_fall;
    @(posedge link_clk_in) disable iff (!lrst_n)
      $changed(serial_indicator_enable_out) |-> !serial_indicator_shift_clock_out;
  endproperty
  a_enable_on_fall: assert property (p_enable_on_fall)
    else $error("enable changed away from a shift clock fall");

  property p_shift_toggle;
    @(posedge link_clk_in) disable iff (!lrst_n)
      serial_indicator_shift_clock_out |=> !serial_indicator_shift_clock_out ##1
        serial_indicator_shift_clock_out;
  endproperty
  a_shift_toggle: assert property (p_shift_toggle)
    else $error("shift clock is not half the link clock");

  property p_frame_length;
    @(posedge link_clk_in) disable iff (!lrst_n)
      $fell(serial_indicator_enable_out) |=> (ena_len == 8'(ENA_CYCLES));
  endproperty
  a_frame_length: assert property (p_frame_length)
    else $error("enable did not last 24 bit periods");

  property p_frames_repeat;
    @(posedge link_clk_in) disable iff (!lrst_n)
      $fell(serial_indicator_enable_out) |-> ##[1:4] serial_indicator_enable_out;
  endproperty
  a_frames_repeat: assert property (p_frames_repeat)
    else $error("serial frame not repeated after its gap");

  property p_first_bit;
    @(posedge link_clk_in) disable iff (!lrst_n)
      $rose(serial_indicator_enable_out) |-> (serial_indicator_bitstream_out == frame[0]) ##2
        (serial_indicator_bitstream_out == frame[1]);
  endproperty
  a_first_bit: assert property (p_first_bit)
    else $error("first serial bit is not port 0 transmit state");

  c_fifo_full: cover property (@(posedge ref_clk_in) disable iff (!rst_n)
    !fifo_wr_ready);
  c_new_frame: cover property (@(posedge link_clk_in) disable iff (!lrst_n)
    new_word && falling && state == QLID_GAP);
  c_repeat_frame: cover property (@(posedge link_clk_in) disable iff (!lrst_n)
    !new_word && have_frame && falling && state == QLID_GAP);
  c_third_col: cover property (@(posedge ref_clk_in) disable iff (!rst_n)
    third_mode_in[1:0] == 2'h3 && collision_in[0]);
endmodule
`default_nettype wire

//--- shared/qlid_pkg.sv
// constants shared by the quad-port indicator driver
// ============================================================
// Overview of operation
// - default first indicator of each port is pulled low while transmitting
// - first indicator selectable to receive activity, link or duplex
// - default second indicator of each port is driven low while receiving
// - second indicator selectable to link, duplex or speed
// - default third indicator of each port is low while link is up
// - third indicator selectable to duplex, speed or collision
// - serial enable goes high while the serial data line carries valid bits
// - a shift clock output times each serial bit
// - each serial frame carries 24 indicator bits, six for each port
`default_nettype none
package qlid_pkg;
  // ============================================================
  // sizes
  localparam int NUM_PORTS     = 4;
  localparam int BITS_PER_PORT = 6;
  localparam int FRAME_BITS    = NUM_PORTS * BITS_PER_PORT;
  localparam int MODE_W        = 2;
  localparam int FIFO_DEPTH    = 4;
  localparam int BIT_CNT_W     = 5;
  // ============================================================
  // per-port status bit positions, also the serial order inside a port
  localparam int ST_TX   = 0;
  localparam int ST_RX   = 1;
  localparam int ST_LINK = 2;
  localparam int ST_DUP  = 3;
  localparam int ST_SPD  = 4;
  localparam int ST_COL  = 5;
  // each indicator picks status bit (base + mode); mode 0 is the default
  localparam int FIRST_BASE  = ST_TX;
  localparam int SECOND_BASE = ST_RX;
  localparam int THIRD_BASE  = ST_LINK;
  localparam logic [MODE_W-1:0] MODE_DEFAULT = 2'h0;
  // ============================================================
  // timing: shift clock is the link clock divided by two
  localparam int SHIFT_CLK_MHZ = 25;
  localparam int LINK_CLK_MHZ  = 2 * SHIFT_CLK_MHZ;
  localparam int LINK_PER_BIT  = LINK_CLK_MHZ / SHIFT_CLK_MHZ;
  // ============================================================
  // reset values
  localparam logic OE_N_RESET = 1'b1;
  localparam logic ENA_RESET  = 1'b0;
  localparam logic [FRAME_BITS-1:0] FRAME_RESET = 24'h000000;
  typedef enum logic {QLID_GAP, QLID_SHIFT} qlid_link_state_t;
endpackage
`default_nettype wire

//--- verification/qlid_led_sr_model.sv
// external serial indicator shift register fed by the serial indicator link
`timescale 1ns/1ps
`default_nettype none
module qlid_led_sr_model (
  // reset
  input  wire logic        rstn_in,
  // serial indicator link
  input  wire logic        shift_clk_in,
  input  wire logic        ena_in,
  input  wire logic        data_in,
  // captured results
  output logic      [23:0] frame_out,
  output int               frame_cnt_out,
  output int               bad_len_out
);
  // ============================================================
  // capture
  logic [23:0] sh;
  int          cnt;
  // bits are taken on the shift clock rise, only while enable is high
  always @(posedge shift_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sh <= 24'h000000;
      cnt <= 0;
      frame_out <= 24'h000000;
      frame_cnt_out <= 0;
      bad_len_out <= 0;
    end else if (ena_in) begin
      if (cnt < 24) begin
        sh[cnt] <= data_in;
      end
      cnt <= cnt + 1;
    end else if (cnt != 0) begin
      // a frame that is not exactly 24 bits long is counted as bad
      if (cnt == 24) begin
        frame_out <= sh;
        frame_cnt_out <= frame_cnt_out + 1;
      end else begin
        bad_len_out <= bad_len_out + 1;
      end
      cnt <= 0;
    end
  end
endmodule
`default_nettype wire

//--- verification/tb_top.sv
// self-checking bench of the quad-port indicator driver
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import qlid_pkg::*;
  // ============================================================
  // clocks, reset and stimulus
  logic        ref_clk = 1'b0;
  logic        link_clk = 1'b0;
  logic        rstn = 1'b0;
  logic [3:0]  tx = 4'h0, rx = 4'h0, lnk = 4'h0, dup = 4'h0, spd = 4'h0, col = 4'h0;
  logic [7:0]  m1 = 8'h00, m2 = 8'h00, m3 = 8'h00;
  logic [3:0]  f_out, f_oen, s_out, s_oen, t_out, t_oen;
  logic        sena, sclk, sdat;
  logic [23:0] frame;
  int          frame_cnt, bad_len;
  int          err_total = 0;
  int          total_checks = 0;
  realtime     t_last = 0.0, t_prev = 0.0;
  always #25 ref_clk = ~ref_clk;
  always #15 link_clk = ~link_clk;
  always @(posedge sclk) begin
    t_prev = t_last;
    t_last = $realtime;
  end
  // open-drain pins with pull-ups: high unless the driver pulls low
  wire  [3:0]  f_pin = f_out | f_oen;
  wire  [3:0]  s_pin = s_out | s_oen;
  wire  [3:0]  t_pin = t_out | t_oen;
  qlid_top u_qlid_top (
    .ref_clk_in(ref_clk), .link_clk_in(link_clk), .rstn_in(rstn),
    .tx_active_in(tx), .rx_active_in(rx), .link_up_in(lnk),
    .full_duplex_in(dup), .speed_100_in(spd), .collision_in(col),
    .first_mode_in(m1), .second_mode_in(m2), .third_mode_in(m3),
    .port_indicator_first_in(f_pin), .port_indicator_first_out(f_out),
    .port_indicator_first_oe_n_out(f_oen),
    .port_indicator_second_in(s_pin), .port_indicator_second_out(s_out),
    .port_indicator_second_oe_n_out(s_oen),
    .port_indicator_third_in(t_pin), .port_indicator_third_out(t_out),
    .port_indicator_third_oe_n_out(t_oen),
    .serial_indicator_enable_out(sena), .serial_indicator_shift_clock_out(sclk),
    .serial_indicator_bitstream_out(sdat)
  );
  qlid_led_sr_model u_qlid_led_sr_model (
    .rstn_in(rstn), .shift_clk_in(sclk), .ena_in(sena), .data_in(sdat),
    .frame_out(frame), .frame_cnt_out(frame_cnt), .bad_len_out(bad_len)
  );
  // ============================================================
  // shared tasks
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  // status vector bit k is port k/6, status k%6, same order as the serial frame
  task automatic set_st(input logic [23:0] v);
    @(posedge ref_clk);
    for (int p = 0; p < 4; p++) begin
      tx[p] <= v[p*6+ST_TX];
      rx[p] <= v[p*6+ST_RX];
      lnk[p] <= v[p*6+ST_LINK];
      dup[p] <= v[p*6+ST_DUP];
      spd[p] <= v[p*6+ST_SPD];
      col[p] <= v[p*6+ST_COL];
    end
  endtask
  // ============================================================
  // scenarios
  task automatic t_ind(input logic [23:0] v, input logic [1:0] m);
    logic [3:0] x1, x2, x3;
    set_st(v);
    m1 <= {4{m}};
    m2 <= {4{m}};
    m3 <= {4{m}};
    repeat (2) @(posedge ref_clk);
    #1;
    for (int p = 0; p < 4; p++) begin
      x1[p] = ~v[p*6+FIRST_BASE+m];
      x2[p] = ~v[p*6+SECOND_BASE+m];
      x3[p] = ~v[p*6+THIRD_BASE+m];
    end
    chk({20'h0, f_oen}, {20'h0, x1}, "first indicator enable");
    chk({20'h0, s_oen}, {20'h0, x2}, "second indicator enable");
    chk({20'h0, t_oen}, {20'h0, x3}, "third indicator enable");
    chk({12'h0, f_out, s_out, t_out}, 24'h000000, "pin drive level");
  endtask
  // a bounded wait: the frame must catch up with the live status
  task automatic wait_frame(input logic [23:0] v);
    for (int n = 0; n < 600 && frame !== v; n++) begin
      @(posedge ref_clk);
    end
    chk(frame, v, "serial frame content");
    chk(24'(bad_len), 24'h000000, "frame length");
    if (frame !== v) begin
      complete_run();
    end
  endtask
  task automatic t_sclk();
    repeat (4) @(posedge ref_clk);
    total_checks++;
    if (t_last - t_prev != 60.0) begin
      err_total++;
      $display("unexpected at %0t: shift clock period", $time);
    end
  endtask
  // with the status still, the last frame must keep coming back
  task automatic t_repeat(input logic [23:0] v);
    int n0;
    n0 = frame_cnt;
    repeat (100) @(posedge ref_clk);
    total_checks++;
    if (frame_cnt < n0 + 3) begin
      err_total++;
      $display("unexpected at %0t: serial frame not repeated", $time);
    end
    chk(frame, v, "repeated frame content");
    chk(24'(bad_len), 24'h000000, "repeated frame length");
  endtask
  // ============================================================
  // main sequence
  initial begin
    repeat (20) @(posedge ref_clk);
    rstn <= 1'b1;
    repeat (3) @(posedge ref_clk);
    for (int m = 0; m < 4; m++) begin
      t_ind(24'h5a3c96, m[1:0]);
      t_ind(24'ha5c369, m[1:0]);
    end
    wait_frame(24'ha5c369);
    t_sclk();
    // rapid changes fill the snapshot queue; only the last must show
    for (int i = 1; i < 8; i++) begin
      set_st(24'h111111 * i);
    end
    set_st(24'hc30f5a);
    wait_frame(24'hc30f5a);
    set_st(24'h000000);
    wait_frame(24'h000000);
    t_repeat(24'h000000);
    complete_run();
  end
endmodule
`default_nettype wire
